// ---- dv/p1ag_board.sv ----
// Purpose: board logic on the pins
// Assumes: board drives every pin the port leaves free
// Notes:   wire level merges both drivers
`default_nettype none
module p1ag_board (
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // port wins where enabled, board elsewhere
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule // p1ag_board
`default_nettype wire

// ---- dv/p1ag_port_checker.sv ----
// Purpose: port checker
// Assumes: mode_i changes only in reset
// Notes:   pins are registered, so causes are one edge back
`default_nettype none
module p1ag_port_checker
  import p1ag_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [2:0]  mode_i,
  input wire logic [7:0]  addr_low_i,
  input wire logic [7:0]  dram_addr_i,
  input wire logic        dram_cycle_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // address modes 1 to 4
  logic ext_m;
  assign ext_m = (mode_i != 3'h0) && (mode_i <= P1AG_MODE_LAST_EXT);
  sequence s_setup; psel && !penable; endsequence
  // guard: first edge after reset still shows reset outputs
  sequence s_ext; ext_m && $past(rst_n_i); endsequence
  a_ext_all_on: assert property (s_ext |-> pin_oe_o == 8'hFF) else $error("oe off");
  a_ext_low: assert property ((s_ext and !$past(dram_cycle_i)) |-> pin_o == $past(addr_low_i))
    else $error("low");
  a_dram_mux: assert property ((s_ext and $past(dram_cycle_i)) |-> pin_o == $past(dram_addr_i))
    else $error("mux");
  a_setup_ready: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready long");
  a_err_ready: assert property (pslverr |-> pready) else $error("err alone");
  a_dir_ones: assert property ((s_setup and (!pwrite && paddr == P1AG_DIR_OFFSET)) |=> prdata == 32'h000000FF)
    else $error("dir read");
  a_unmapped_err: assert property ((s_setup and (paddr == 20'h00100)) |=> pslverr && prdata == 32'h0)
    else $error("unmapped");
endmodule // p1ag_port_checker
bind p1ag_port p1ag_port_checker i_p1ag_port_checker (
  .mclk_i       (mclk_i),
  .rst_n_i      (rst_n_i),
  .mode_i       (mode_i),
  .addr_low_i   (addr_low_i),
  .dram_addr_i  (dram_addr_i),
  .dram_cycle_i (dram_cycle_i),
  .psel         (psel),
  .penable      (penable),
  .pwrite       (pwrite),
  .paddr        (paddr),
  .prdata       (prdata),
  .pready       (pready),
  .pslverr      (pslverr),
  .pin_o        (pin_o),
  .pin_oe_o     (pin_oe_o)
);
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: port bench
// Assumes: one apb master, reads checked from a queue
// Notes:   every mode gets its own reset
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb;
  import p1ag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, rst_n_i = 0, dram_cycle_i = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, standby_o;
  logic [2:0] mode_i = 3'h7;
  logic [7:0] addr_low_i = 0, dram_addr_i = 0, ext = 0, d, v, dd, pin_i, pin_o, pin_oe_o;
  logic [19:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [32:0] exp_q[$];
  logic [32:0] exp_r;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #50 mclk_i = ~mclk_i;
  p1ag_port i_p1ag_port (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mode_i(mode_i), .addr_low_i(addr_low_i),
    .dram_addr_i(dram_addr_i), .dram_cycle_i(dram_cycle_i), .pin_i(pin_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .standby_o(standby_o));
  p1ag_board i_p1ag_board (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_i(ext), .pin_i(pin_i));
  // one transfer; reads note {pslverr, prdata} expected
  task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] wd, input logic [32:0] e);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    if (!w) exp_q.push_back(e);
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // read results taken at the completing edge
  always @(posedge mclk_i) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_r = exp_q.pop_front();
      `CHK({pslverr, prdata}, exp_r)
    end
  end
  // hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(17455));
    for (int m = 1; m < 8; m++) begin
      mode_i <= m[2:0];
      rst_n_i <= 1'b0;
      ext <= 8'($urandom);
      addr_low_i <= 8'($urandom);
      dram_cycle_i <= 1'b0;
      repeat (m == 1 ? 12 : 3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      // synchroniser and filter need a few edges
      repeat (8) @(posedge mclk_i);
      dd = (m <= 4) ? 8'hFF : 8'h00;
      `CHK(pin_oe_o, dd)
      apb(1'b0, P1AG_DATA_OFFSET, 8'h00, {25'h0, ext & ~dd});
      d = 8'($urandom);
      v = 8'($urandom);
      apb(1'b1, P1AG_DIR_OFFSET, d, 33'h0);
      apb(1'b1, P1AG_DATA_OFFSET, v, 33'h0);
      dd = (m <= 4) ? 8'hFF : d;
      repeat (2) @(posedge mclk_i);
      `CHK(pin_oe_o, dd)
      `CHK(pin_o & dd, (m <= 5 ? addr_low_i : v) & dd)
      apb(1'b0, P1AG_DATA_OFFSET, 8'h00, {25'h0, (v & dd) | (ext & ~dd)});
      apb(1'b0, P1AG_DIR_OFFSET, 8'h00, {25'h0, P1AG_DIR_READBACK});
      apb(1'b0, 20'h00100, 8'h00, {1'b1, 32'h0});
      apb(1'b1, P1AG_CTRL_OFFSET, 8'h01, 33'h0);
      repeat (3) @(posedge mclk_i);
      `CHK({standby_o, pin_oe_o}, {1'b1, dd})
      dram_cycle_i <= (m <= 4);
      dram_addr_i <= 8'($urandom);
      repeat (2) @(posedge mclk_i);
      if (m <= 4) `CHK(pin_o, dram_addr_i)
      $display("test mode %0d done", m);
    end
    stop_test();
  end
endmodule // tb
`default_nettype wire

// ---- pkg/p1ag_pkg.sv ----
// Purpose: shared constants for the port with low address byte
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   printed offsets are multiples of four, so they are byte addresses
`default_nettype none
package p1ag_pkg;
  localparam int          P1AG_AW            = 20;
  localparam int          P1AG_W             = 8;
  localparam logic [19:0] P1AG_DIR_OFFSET    = 20'hEE000;
  localparam logic [19:0] P1AG_DATA_OFFSET   = 20'hFFFD0;
  localparam logic [19:0] P1AG_CTRL_OFFSET   = 20'hFFFD4;
  localparam logic [7:0]  P1AG_DIR_RST_ADDR  = 8'hFF;
  localparam logic [7:0]  P1AG_DIR_RST_GPIO  = 8'h00;
  localparam logic [7:0]  P1AG_DATA_RST      = 8'h00;
  localparam logic [7:0]  P1AG_DIR_READBACK  = 8'hFF;
  localparam logic [2:0]  P1AG_MODE_LAST_EXT = 3'h4;
  localparam logic [2:0]  P1AG_MODE_MIXED    = 3'h5;
  localparam int          P1AG_CTRL_STBY_BIT = 0;
endpackage : p1ag_pkg
`default_nettype wire

// ---- rtl/p1ag_pin_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to mclk_i
// Notes:   stage one feeds only stage two
`default_nettype none
module p1ag_pin_sync (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] level_o
);
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;

  // shift chain; stage one is read by stage two only
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a change per bit only once stages two and three agree
  genvar g;
  for (g = 0; g < 8; g++) begin : g_bit
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        level_o[g] <= 1'b0;
      end else if (s2_r[g] == s3_r[g]) begin
        level_o[g] <= s3_r[g];
      end
    end
  end
endmodule // p1ag_pin_sync
`default_nettype wire

// ---- rtl/p1ag_port.sv ----
// Purpose: 8-bit port, generic i/o or low address byte by operating mode
// Assumes: mode_i is stable around reset; addr/row-col mux arrives ready
// Notes:   APB slave, zero wait states, pslverr on unmapped addresses
//          direction is write only and answers all ones when read
//          pins are registered, so a register write shows one edge later
//          standby only reports; nothing here stops the clock
//
// How it works
// - per-pin direction register plus a separate output data register
// - modes 1 to 4 drive all pins as address low byte
// - mode 5 pin is address output if direction 1, else input
// - modes 6 and 7 are generic i/o chosen by direction bit
// - direction register is 8 bits and write only
// - reset direction is all ones in modes 1-4, zeros in 5-7
// - output data register is 8-bit read/write, reset to zero
// - with dram in areas 2-5 pins carry multiplexed row/column address
// - port read gives pin level where direction 0, data where 1
// - in modes 1 to 4 direction bits stay 1, writes ignored
// - in modes 5 to 7 direction reads as all ones
// - registers hold contents in software standby, outputs keep driving
`default_nettype none
module p1ag_port
  import p1ag_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic [7:0]  addr_low_i,
  input  wire logic [7:0]  dram_addr_i,
  input  wire logic        dram_cycle_i,
  input  wire logic [7:0]  pin_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [19:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  pin_o,
  output logic      [7:0]  pin_oe_o,
  output logic             standby_o
);
  logic [7:0] dir_r;
  logic [7:0] data_r;
  logic       stby_r;
  logic [7:0] level;
  logic       ext_mode;
  logic       mixed_mode;
  logic       acc;
  logic       hit_dir;
  logic       hit_data;
  logic       hit_ctrl;
  logic [7:0] addr_sel;
  logic [7:0] oe_nxt;
  logic [7:0] out_nxt;
  logic [7:0] port_rd;
  logic       setup_ph;
  logic       hit_any;
  logic       wr_dir;
  logic       wr_data;
  logic       wr_ctrl;
  logic       err_nxt;
  logic [31:0] rd_nxt;
  logic       stby_q_r;

  p1ag_pin_sync u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (pin_i),
    .level_o (level)
  );

  // mode decode: modes 1-4 are the address-only expanded modes
  // mode 0 is not a real mode; it falls through to plain i/o
  assign ext_mode   = (mode_i != 3'h0) && (mode_i <= P1AG_MODE_LAST_EXT);
  assign mixed_mode = (mode_i == P1AG_MODE_MIXED);

  // apb decode; access phase takes the transfer with no wait states
  assign acc      = psel && penable;
  assign hit_dir  = (paddr == P1AG_DIR_OFFSET);
  assign hit_data = (paddr == P1AG_DATA_OFFSET);
  assign hit_ctrl = (paddr == P1AG_CTRL_OFFSET);

  // setup-cycle strobe; reply regs load here so they stand in the access cycle
  assign setup_ph = psel && !penable;
  assign hit_any  = hit_dir || hit_data || hit_ctrl;

  // write strobes; an unmapped address matches none, so its write is dropped
  assign wr_dir   = acc && pwrite && hit_dir;
  assign wr_data  = acc && pwrite && hit_data;
  assign wr_ctrl  = acc && pwrite && hit_ctrl;

  // direction register; ext modes pin it to ones so writes cannot stick
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dir_r <= ext_mode ? P1AG_DIR_RST_ADDR : P1AG_DIR_RST_GPIO;
    end else if (ext_mode) begin
      dir_r <= P1AG_DIR_RST_ADDR;
    end else if (wr_dir) begin
      dir_r <= pwdata[7:0];
    end
  end

  // output data register; standby does not touch it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      data_r <= P1AG_DATA_RST;
    end else if (wr_data) begin
      data_r <= pwdata[7:0];
    end
  end

  // standby flag only reported out; registers keep state through it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      stby_r <= 1'b0;
    end else if (wr_ctrl) begin
      stby_r <= pwdata[P1AG_CTRL_STBY_BIT];
    end
  end

  // dram row/column address replaces the plain address during its cycles
  assign addr_sel = dram_cycle_i ? dram_addr_i : addr_low_i;

  // per-pin function select; a mode 5 pin that points out shows the address,
  // never the data register, so software cannot disturb the external bus
  genvar g;
  for (g = 0; g < 8; g++) begin : g_pin
    always_comb begin
      if (ext_mode) begin
        oe_nxt[g]  = 1'b1;
        out_nxt[g] = addr_sel[g];
      end else if (mixed_mode) begin
        oe_nxt[g]  = dir_r[g];
        out_nxt[g] = addr_sel[g];
      end else begin
        oe_nxt[g]  = dir_r[g];
        out_nxt[g] = data_r[g];
      end
    end
  end

  // port read mixes pin level and stored data per direction bit
  assign port_rd = (dir_r & data_r) | (~dir_r & level);

  // registered enables; one cycle behind the selection, glitch free
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_oe_o <= 8'h00;
    end else begin
      pin_oe_o <= oe_nxt;
    end
  end

  // registered pin values; same delay as the enables so both move together
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_o <= 8'h00;
    end else begin
      pin_o <= out_nxt;
    end
  end

  // read mux; direction is write only, so it always answers all ones
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (setup_ph && !pwrite) begin
      if (hit_dir) begin
        rd_nxt = {24'h00_0000, P1AG_DIR_READBACK};
      end else if (hit_data) begin
        rd_nxt = {24'h00_0000, port_rd};
      end else if (hit_ctrl) begin
        rd_nxt = {31'h0000_0000, stby_r};
      end
    end
  end

  // error answer; unmapped addresses fail but leave every register alone
  assign err_nxt = setup_ph && !hit_any;

  // ready one cycle after setup, so the access phase never waits
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ph;
    end
  end

  // error flag stands beside ready for the one access cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= err_nxt;
    end
  end

  // read data registered at setup; zero outside a read keeps the bus quiet
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rd_nxt;
    end
  end

  // standby reported one cycle late; the extra stage keeps the output a flop
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      stby_q_r <= 1'b0;
    end else begin
      stby_q_r <= stby_r;
    end
  end

  // plain wire from the flop above, no logic in the path
  assign standby_o = stby_q_r;
endmodule // p1ag_port
`default_nettype wire
